// ==== design/ascd_byte_shift.sv ====
`timescale 1ns/1ps
// Byte shifter on the link clock: samples din, drives out MSB first
module ascd_byte_shift
  import ascd_pkg::*;
(
  // Link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  // Byte side
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output logic            rx_done,
  output logic [2:0]      bit_cnt
);
  logic [6:0] sh_r;
  // Capture on rising edge; framing sees the whole byte at its eighth rise
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt <= 3'h0;
      sh_r    <= 7'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      sh_r    <= {sh_r[5:0], din};
    end
  end
  assign rx_byte = {sh_r, din};
  assign rx_done = (bit_cnt == 3'h7);
  // Bit changes at a rise and stands a full period, so a host behind two flops still sees it
  assign dout = tx_byte[~bit_cnt];
endmodule

// ==== design/ascd_dev.sv ====
`timescale 1ns/1ps
module ascd_dev
  import ascd_pkg::*;
#(
  parameter int NREG = 19
)
(
  // Link, device end
  ascd_link_if.dev      lnk,
  // Converter side, system clock domain
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        crc_enable,
  input  wire logic        status_enable,
  input  wire logic [23:0] conv_data,
  input  wire logic        conv_valid,
  input  wire logic [7:0]  status_byte,
  input  wire logic [7:0]  reg_rdata,
  output logic [4:0]       reg_addr,
  output logic             cmd_reset,
  output logic             cmd_start,
  output logic             cmd_stop,
  output logic             cal_sysofs,
  output logic             cal_gain,
  output logic             cal_selfofs,
  output logic             check_error_flag
);
  // ==========================================================
  // Result buffer, system domain
  logic [31:0] buf_r;
  logic [7:0]  reg_hold_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      buf_r <= 32'h0;
    else if (conv_valid)
      buf_r <= {status_byte, conv_data};
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reg_hold_r <= 8'h00;
    else
      reg_hold_r <= ({1'b0, reg_addr} < NREG[5:0]) ? reg_rdata : ASCD_ZERO;
  end

  // ==========================================================
  // Link domain framing
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic        rx_done;
  logic [2:0]  bit_cnt;
  logic [3:0]  byte_idx_r;
  logic [7:0]  b1_r, b2_r, crc_r, ocrc_r;
  logic [31:0] snap_r;
  logic        exec_r;
  logic [2:0]  evt_code_r;
  logic        err_r;
  logic        crc_mode_s1, crc_mode_s2, stat_s1, stat_s2;

  ascd_byte_shift u_sh (
    .sclk    (lnk.sclk),
    .cs_n    (lnk.cs_n),
    .din     (lnk.din),
    .dout    (lnk.serial_out_ready),
    .tx_byte (tx_byte),
    .rx_byte (rx_byte),
    .rx_done (rx_done),
    .bit_cnt (bit_cnt)
  );

  always_ff @(posedge lnk.sclk)
  begin
    crc_mode_s1 <= crc_enable;
    crc_mode_s2 <= crc_mode_s1;
    stat_s1     <= status_enable;
    stat_s2     <= stat_s1;
  end

  wire        is_rd   = (b1_r == ASCD_OP_RDATA);
  wire        is_rr   = (b1_r[7:5] == ASCD_REGISTER_READ_CMD_BASE);
  wire [7:0]  exp_crc = ascd_crc8(ascd_crc8(ASCD_CRC_INIT, b1_r), b2_r);
  wire        crc_ok  = (crc_r == exp_crc);
  wire [3:0]  exec_at = crc_mode_s2 ? ASCD_CMD_BYTES_C : ASCD_CMD_BYTES;
  wire [3:0]  dbase   = crc_mode_s2 ? 4'h4 : 4'h2;
  wire [3:0]  doff    = byte_idx_r - dbase;
  wire [7:0]  st_b    = snap_r[31:24];
  wire [7:0]  crc_dat = stat_s2 ? ascd_crc8(ascd_crc8(ascd_crc8(ascd_crc8(ASCD_CRC_INIT, st_b),
                        snap_r[23:16]), snap_r[15:8]), snap_r[7:0])
                        : ascd_crc8(ascd_crc8(ascd_crc8(ASCD_CRC_INIT, snap_r[23:16]), snap_r[15:8]),
                        snap_r[7:0]);
  wire [3:0]  dsel    = stat_s2 ? doff : doff + 4'h1;

  // Byte slot after byte_idx_r complete bytes
  always_comb
  begin
    tx_byte = ASCD_FILL;
    if (byte_idx_r == 4'h1)
      tx_byte = b1_r;
    else if (crc_mode_s2 && byte_idx_r == 4'h2)
      tx_byte = b2_r;
    else if (crc_mode_s2 && byte_idx_r == 4'h3)
      tx_byte = crc_ok ? ocrc_r : ~ocrc_r;
    else if (byte_idx_r >= dbase && (!crc_mode_s2 || crc_ok))
    begin
      if (is_rr && doff == 4'h0)
        tx_byte = snap_r[7:0];
      else if (is_rr && doff == 4'h1 && crc_mode_s2)
        tx_byte = ascd_crc8(ASCD_CRC_INIT, snap_r[7:0]);
      else if (is_rd && dsel == 4'h0)
        tx_byte = st_b;
      else if (is_rd && dsel == 4'h1)
        tx_byte = snap_r[23:16];
      else if (is_rd && dsel == 4'h2)
        tx_byte = snap_r[15:8];
      else if (is_rd && dsel == 4'h3)
        tx_byte = snap_r[7:0];
      else if (is_rd && dsel == 4'h4 && crc_mode_s2)
        tx_byte = crc_dat;
    end
  end

  // Frame state; cs_n high clears the frame
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n)
  begin
    if (lnk.cs_n)
      byte_idx_r <= 4'h0;
    else if (rx_done && byte_idx_r != 4'hF)
      byte_idx_r <= byte_idx_r + 4'h1;
  end

  wire last_byte = rx_done && (byte_idx_r + 4'h1 == exec_at);
  always_ff @(posedge lnk.sclk)
  begin
    if (rx_done && byte_idx_r == 4'h0)
      b1_r <= rx_byte;
    if (rx_done && byte_idx_r == 4'h1)
    begin
      b2_r   <= rx_byte;
      ocrc_r <= ascd_crc8(ascd_crc8(ASCD_CRC_INIT, b1_r), rx_byte);
    end
    if (rx_done && byte_idx_r == 4'h2)
      crc_r <= rx_byte;
    // Snapshot whole word once so a read is never mixed
    if (rx_done && byte_idx_r == 4'h1)
      snap_r <= is_rr ? {24'h0, reg_hold_r} : buf_r;
  end

  // Event levels held until select rises; cs_n gives them a known start although sclk stops
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n)
  begin
    if (lnk.cs_n)
    begin
      exec_r <= 1'b0;
      err_r  <= 1'b0;
    end
    else
    begin
      if (last_byte && (!crc_mode_s2 || crc_ok))
        exec_r <= 1'b1;
      if (last_byte && crc_mode_s2 && !crc_ok)
        err_r <= 1'b1;
    end
  end
  always_ff @(posedge lnk.sclk)
  begin
    if (last_byte)
      evt_code_r <= (b1_r == ASCD_OP_RESET) ? 3'h1 : (b1_r == ASCD_OP_START) ? 3'h2 :
                    (b1_r == ASCD_OP_STOP) ? 3'h3 : (b1_r == ASCD_OP_SYSOFS) ? 3'h4 :
                    (b1_r == ASCD_OP_GAIN) ? 3'h5 : (b1_r == ASCD_OP_SELFOFS) ? 3'h6 : 3'h0;
  end

  // ==========================================================
  // System domain command pulses
  logic [2:0] ev_s, er_s;
  logic [4:0] rr_addr_s1;
  always_ff @(posedge clock)
  begin
    ev_s       <= {ev_s[1:0], exec_r};
    er_s       <= {er_s[1:0], err_r};
    rr_addr_s1 <= b1_r[4:0];
    reg_addr   <= rr_addr_s1;
  end
  wire ev_p = ev_s[1] && !ev_s[2];
  wire er_p = er_s[1] && !er_s[2];
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cmd_reset <= 1'b0; cmd_start <= 1'b0; cmd_stop <= 1'b0;
      cal_sysofs <= 1'b0; cal_gain <= 1'b0; cal_selfofs <= 1'b0;
      check_error_flag <= 1'b0;
    end
    else
    begin
      cmd_reset   <= ev_p && evt_code_r == 3'h1;
      cmd_start   <= ev_p && evt_code_r == 3'h2;
      cmd_stop    <= ev_p && evt_code_r == 3'h3;
      cal_sysofs  <= ev_p && evt_code_r == 3'h4;
      cal_gain    <= ev_p && evt_code_r == 3'h5;
      cal_selfofs <= ev_p && evt_code_r == 3'h6;
      if (er_p)
        check_error_flag <= 1'b1;
      else if (ev_p && evt_code_r == 3'h1)
        check_error_flag <= 1'b0;
    end
  end
endmodule

// ==== design/ascd_host.sv ====
`timescale 1ns/1ps
module ascd_host
  import ascd_pkg::*;
(
  // Link, host end
  ascd_link_if.host     lnk,
  // User side
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        req,
  input  wire logic [7:0]  op,
  input  wire logic [3:0]  nbytes,
  input  wire logic        crc_mode,
  output logic             busy,
  output logic             done,
  output logic [31:0]      resp
);
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_END} ascd_hst_t;
  ascd_hst_t   st_r;
  logic [3:0]  div_r, byte_r;
  logic [2:0]  bit_r;
  logic [7:0]  tx_r, rx_r, op_r;
  logic [3:0]  n_r;
  logic        cm_r;
  logic        sdo_s1, sdo_s2;
  always_ff @(posedge clock)
  begin
    sdo_s1 <= lnk.serial_out_ready;
    sdo_s2 <= sdo_s1;
  end
  wire       tick = (div_r == ASCD_LINK_DIV);
  wire [7:0] crc2 = ascd_crc8(ascd_crc8(ASCD_CRC_INIT, op_r), ASCD_ZERO);
  // Next byte: opcode, zero second byte, CRC, then zeros
  wire [7:0] nxt  = (byte_r == 4'h1 && cm_r) ? crc2 : ASCD_ZERO;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_r <= H_IDLE; div_r <= 4'h0; byte_r <= 4'h0; bit_r <= 3'h0;
      lnk.sclk <= 1'b0; lnk.cs_n <= 1'b1; lnk.din <= 1'b0;
      busy <= 1'b0; done <= 1'b0; resp <= 32'h0; tx_r <= 8'h00; rx_r <= 8'h00;
      op_r <= 8'h00; n_r <= 4'h0; cm_r <= 1'b0;
    end
    else
    begin
      done  <= 1'b0;
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      case (st_r)
        H_IDLE:
          if (req)
          begin
            op_r <= op; n_r <= nbytes; cm_r <= crc_mode;
            tx_r <= {op[6:0], 1'b0}; lnk.din <= op[7];
            lnk.cs_n <= 1'b0; busy <= 1'b1; byte_r <= 4'h0; bit_r <= 3'h0;
            st_r <= H_LOW; div_r <= 4'h0;
          end
        H_LOW:
          if (tick)
          begin
            lnk.sclk <= 1'b1; st_r <= H_HIGH;
            rx_r <= {rx_r[6:0], sdo_s2};
          end
        H_HIGH:
          if (tick)
          begin
            lnk.sclk <= 1'b0;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7)
            begin
              resp   <= {resp[23:0], rx_r};
              byte_r <= byte_r + 4'h1;
              lnk.din <= nxt[7]; tx_r <= {nxt[6:0], 1'b0};
              st_r <= (byte_r + 4'h1 == n_r) ? H_END : H_LOW;
            end
            else
            begin
              lnk.din <= tx_r[7]; tx_r <= {tx_r[6:0], 1'b0};
              st_r <= H_LOW;
            end
          end
        H_END:
          if (tick)
          begin
            lnk.cs_n <= 1'b1; busy <= 1'b0; done <= 1'b1; st_r <= H_IDLE;
          end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== design/ascd_link_if.sv ====
`timescale 1ns/1ps
interface ascd_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic serial_out_ready;
  modport dev (input sclk, input cs_n, input din, output serial_out_ready);
  modport host (output sclk, output cs_n, output din, input serial_out_ready);
endinterface

// ==== design/ascd_pkg.sv ====
// Overview of operation
// - Reset opcode restarts converter and registers
// - Start opcode begins conversions
// - Stop opcode ends conversions
// - Latest result buffered for reading anytime
// - Overlapping read returns old or new, unmixed
// - Data read carries three to five bytes
// - Result sent MSB, MID, LSB after status
// - CRC data read spans eight bytes, nine with status, ends CRC
// - System offset opcode triggers offset calibration
// - Gain opcode triggers full-scale calibration
// - Self offset opcode triggers internal calibration
// - Host adds address to read base, one each
// - Register byte shifted most significant first
// - Out-of-range register read returns zero
// - CRC register read: data byte five, CRC six
// - Plain register read takes three bytes
// - Fill byte ones, then echo of byte one
// - CRC mode: host zero, CRC; device echo, CRC
// - Host may hold select low for reads
// - Register address is five bits
// - CRC-8 poly 107h, preset all ones
// - Mismatch: no execute, inverted CRC, error flag
package ascd_pkg;
  localparam logic [7:0] ASCD_OP_RESET    = 8'h06;
  localparam logic [7:0] ASCD_OP_START    = 8'h08;
  localparam logic [7:0] ASCD_OP_STOP     = 8'h0A;
  localparam logic [7:0] ASCD_OP_RDATA    = 8'h12;
  localparam logic [7:0] ASCD_OP_SYSOFS   = 8'h16;
  localparam logic [7:0] ASCD_OP_GAIN     = 8'h17;
  localparam logic [7:0] ASCD_OP_SELFOFS  = 8'h19;
  localparam logic [2:0] ASCD_REGISTER_READ_CMD_BASE   = 3'h1;
  localparam logic [7:0] ASCD_FILL        = 8'hFF;
  localparam logic [7:0] ASCD_ZERO        = 8'h00;
  localparam logic [7:0] ASCD_CRC_POLY    = 8'h07;
  localparam logic [7:0] ASCD_CRC_INIT    = 8'hFF;
  localparam logic [4:0] ASCD_NUM_REGS    = 5'h13;
  localparam logic [3:0] ASCD_CMD_BYTES   = 4'h2;
  localparam logic [3:0] ASCD_CMD_BYTES_C = 4'h4;
  localparam logic [3:0] ASCD_LINK_DIV    = 4'h3;

  typedef enum {ASCD_K_NONE, ASCD_K_RDATA, ASCD_K_REGISTER_READ_CMD} ascd_kind_t;

  // Bitwise CRC step over one byte, MSB first
  function automatic logic [7:0] ascd_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ ASCD_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// ==== tb/adc_serial_command_decoder_bench.sv ====
`timescale 1ns/1ps
// ==========================================
// Bench: host and device face each other
module adc_serial_command_decoder_bench
  import ascd_pkg::*;
;
  logic        clock, sys_rst, req, crc_mode, crc_enable;
  logic        status_enable, conv_valid, check_error_flag, done;
  logic [7:0]  op, status_byte, reg_rdata, c, d;
  logic [3:0]  nbytes;
  logic [23:0] conv_data;
  logic [4:0]  reg_addr, a;
  logic [5:0]  pl;
  logic [31:0] resp;
  logic [7:0]  regs [32];
  logic [7:0]  q [$];
  logic [7:0]  ops [6] = '{8'h06, 8'h08, 8'h0A, 8'h16, 8'h17, 8'h19};
  int          err_total, compares, seed_v, eflag;
  int          pcnt [6];
  int          ecnt [6];

  ascd_link_if lnk ();
  ascd_dev #(.NREG(19)) u_ascd_dev (.lnk(lnk), .clock(clock), .sys_rst(sys_rst),
    .crc_enable(crc_enable), .status_enable(status_enable), .conv_data(conv_data),
    .conv_valid(conv_valid), .status_byte(status_byte), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .cmd_reset(pl[0]), .cmd_start(pl[1]), .cmd_stop(pl[2]),
    .cal_sysofs(pl[3]), .cal_gain(pl[4]), .cal_selfofs(pl[5]), .check_error_flag(check_error_flag));
  ascd_host u_ascd_host (.lnk(lnk), .clock(clock), .sys_rst(sys_rst), .req(req), .op(op),
    .nbytes(nbytes), .crc_mode(crc_mode), .busy(), .done(done), .resp(resp));
  ascd_link_monitor u_ascd_link_monitor (.clock(clock), .sys_rst(sys_rst), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .din(lnk.din), .serial_out_ready(lnk.serial_out_ready));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Register file and pulse counters
  always @(posedge clock) reg_rdata <= regs[reg_addr];
  always @(posedge clock)
    for (int i = 0; i < 6; i++)
      if (pl[i] === 1'b1)
        pcnt[i]++;

  // ==========================================
  // Model and checks
  function automatic logic [7:0] crc_m(input logic [7:0] x, input logic [7:0] y);
    x = x ^ y;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic head(input logic [7:0] o, input bit m);
    q = {8'hFF, o};
    if (m)
      q = {q, 8'h00, crc_m(crc_m(8'hFF, o), 8'h00)};
  endtask

  // Frame length follows the expected reply queue
  task automatic run(input string nm, input logic [7:0] o, input bit m, input bit ce);
    logic [31:0] e;
    int          t;
    e = 32'h0;
    foreach (q[i]) e = {e[23:0], q[i]};
    crc_enable <= ce;
    crc_mode <= m;
    op <= o;
    nbytes <= 4'(q.size());
    req <= 1'b1;
    @(posedge clock);
    req <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000)
    begin
      @(negedge clock);
      t++;
    end
    if (t >= 3000)
      err_total++;
    repeat (12) @(posedge clock);
    chk(nm, e, q.size() < 4 ? resp & ~(32'hFFFFFFFF << (8 * q.size())) : resp);
    for (int i = 0; i < 6; i++)
      chk("pulse", 32'(ecnt[i]), 32'(pcnt[i]));
    chk("flag", 32'(eflag), {31'h0, check_error_flag});
    $display("test %s done", nm);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial
  begin
    sys_rst = 1'b1; req = 1'b0; op = 8'h00; nbytes = 4'h0; crc_mode = 1'b0; crc_enable = 1'b0;
    status_enable = 1'b0; conv_valid = 1'b0; conv_data = 24'h0; status_byte = 8'h00;
    err_total = 0; compares = 0; eflag = 0;
    seed_v = $urandom(32);
    foreach (regs[i]) regs[i] = 8'($urandom());
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    head(8'h08, 1'b0);
    q = {q, 8'h00, ~crc_m(crc_m(8'hFF, 8'h08), 8'h00)};
    eflag = 1;
    run("crc_bad", 8'h08, 1'b0, 1'b1);
    q = {8'hFF};
    run("abort", 8'h0A, 1'b0, 1'b0);
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 6; i++)
      begin
        head(ops[i], m[0]);
        ecnt[i]++;
        if (i == 0)
          eflag = 0;
        run("control", ops[i], m[0], m[0]);
      end
    for (int k = 0; k < 4; k++)
    begin
      conv_data <= 24'($urandom());
      status_byte <= 8'($urandom());
      status_enable <= k[1];
      conv_valid <= 1'b1;
      @(posedge clock);
      conv_valid <= 1'b0;
      head(8'h12, k[0]);
      if (k[1])
        q.push_back(status_byte);
      for (int b = 2; b >= 0; b--)
        q.push_back(conv_data[8 * b +: 8]);
      c = 8'hFF;
      for (int j = k[0] ? 4 : 2; j < q.size(); j++)
        c = crc_m(c, q[j]);
      if (k[0])
        q.push_back(c);
      run("rdata", 8'h12, k[0], k[0]);
    end
    for (int k = 0; k < 6; k++)
    begin
      a = k < 2 ? 5'h12 + 5'(k) : 5'($urandom());
      d = a < 5'h13 ? regs[a] : 8'h00;
      head(8'h20 + 8'(a), k[0]);
      q.push_back(d);
      if (k[0])
        q.push_back(crc_m(8'hFF, d));
      run("register_read_cmd", 8'h20 + 8'(a), k[0], k[0]);
    end
    test_done();
  end

  // Whole run needs about 6.6k cycles
  initial
  begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule

// ==== tb/ascd_link_monitor.sv ====
`timescale 1ns/1ps
// ==========================================
// Link checker, system clock domain
module ascd_link_monitor (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic serial_out_ready
);
  logic       sclk_r;
  logic [7:0] nbits_r;
  logic [7:0] b1_r;
  logic       sor_r;
  wire        rise = sclk && !sclk_r;

  // Host makes sclk from this clock, so edges are seen exactly
  always_ff @(posedge clock)
  begin
    sclk_r <= sclk;
    sor_r <= serial_out_ready;
    nbits_r <= (sys_rst || cs_n) ? 8'h00 : nbits_r + {7'h00, rise};
    if (rise && nbits_r < 8'h08)
      b1_r <= {b1_r[6:0], din};
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_fill; rise && nbits_r < 8'h08 |-> sor_r; endproperty
  property p_echo; rise && nbits_r[7:3] == 5'h01 |-> sor_r == b1_r[~nbits_r[2:0]]; endproperty
  property p_idle; cs_n |-> !sclk; endproperty
  property p_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
  property p_setup; $fell(cs_n) |-> !sclk[*3]; endproperty
  property p_din; sclk && $past(sclk) |-> $stable(din); endproperty
  property p_whole; $rose(cs_n) |-> nbits_r[2:0] == 3'h0; endproperty
  property p_rst; $fell(sys_rst) |-> cs_n && !sclk; endproperty
  a_fill: assert property (p_fill) else $error("fill bit low");
  a_echo: assert property (p_echo) else $error("echo bit wrong");
  a_idle: assert property (p_idle) else $error("clock moves while idle");
  a_high: assert property (p_high) else $error("clock high phase wrong");
  a_setup: assert property (p_setup) else $error("clock too soon after select");
  a_din: assert property (p_din) else $error("data moved while clock high");
  a_whole: assert property (p_whole) else $error("frame ends mid byte");
  a_rst: assert property (p_rst) else $error("link not idle after reset");
  c_short: cover property ($rose(cs_n) && nbits_r == 8'h10);
  c_register_read_cmd: cover property ($rose(cs_n) && nbits_r == 8'h18);
  c_long: cover property (rise && nbits_r == 8'h47);
endmodule
